// ==== common/dmaca_regs.vh ====
`ifndef DMACA_REGS_VH
`define DMACA_REGS_VH

// Register map (byte addresses on the Avalon slave)
`define DMACA_OFF_GOR 7'h00
`define DMACA_OFF_CHAN 7'h40
`define DMACA_SUB_CCR 2'h0
`define DMACA_SUB_SAR 2'h1
`define DMACA_SUB_DAR 2'h2
`define DMACA_SUB_CNT 2'h3

// Global operation register fields
`define DMACA_GOR_MEN 0
`define DMACA_GOR_NMI_ABORT_FLAG 1
`define DMACA_GOR_NARROW 2
`define DMACA_GOR_PRI_LO 8
`define DMACA_GOR_PRI_HI 9
`define DMACA_GOR_BUSY 16
`define DMACA_GOR_CHAN_LO 17
`define DMACA_GOR_CHAN_HI 18

// Channel control register fields
`define DMACA_CCR_CE 0
`define DMACA_CCR_TE 1
`define DMACA_CCR_SZ_LO 2
`define DMACA_CCR_SZ_HI 3
`define DMACA_CCR_BURST 4
`define DMACA_CCR_IND 5
`define DMACA_CCR_SINGLE 6
`define DMACA_CCR_DEV2MEM 7
`define DMACA_CCR_ONCHIP 8
`define DMACA_CCR_SRCINC 9
`define DMACA_CCR_DSTINC 10
`define DMACA_CCR_REFUSED 11
`define DMACA_CCR_TE_MASK 11'h002

// Transfer unit sizes
`define DMACA_SZ_BYTE 2'h0
`define DMACA_SZ_WORD 2'h1
`define DMACA_SZ_LONG 2'h2
`define DMACA_SZ_QUAD 2'h3

// Priority select encodings and channel orderings (lowest slot first)
`define DMACA_PRI_FIX_A 2'h0
`define DMACA_PRI_FIX_B 2'h1
`define DMACA_PRI_FIX_C 2'h2
`define DMACA_PRI_RR 2'h3
`define DMACA_ORDER_FIX_A 8'hE4
`define DMACA_ORDER_FIX_B 8'h78
`define DMACA_ORDER_FIX_C 8'hD2
`define DMACA_ORDER_RR_RESET 8'hE4

// Reset values
`define DMACA_CCR_RESET 11'h000
`define DMACA_ADDR_RESET 32'h0000_0000
`define DMACA_CNT_RESET 24'h00_0000

`endif

// ==== src/dmaca_core.v ====
// Summary of operation
// (RULE1) A channel runs only if enabled, master enabled, not ended, not aborted.
// (RULE2) Simultaneous requests: exactly one channel granted, by active order.
// (RULE3) Two-bit priority select picks fixed or round-robin ordering.
// (RULE4) Fixed orderings never change; three distinct fixed orders exist.
// (RULE5) Encodings 0..2 are fixed orders, 3 is round-robin.
// (RULE6) Round-robin: finished channel drops to lowest after each unit.
// (RULE7) Round-robin order resets to 0,1,2,3 highest first.
// (RULE8) Requests during a unit wait; next grant uses updated order.
// (RULE9) Dual address drives source and destination in separate cycles.
// (RULE10) Direct dual: read source into buffer, then write to destination.
// (RULE11) Indirect (channel 3): fetch pointer, read at pointer, write out.
// (RULE12) Pointer is always fetched as a full 32-bit value.
// (RULE13) Indirect mode refuses 16-byte units.
// (RULE14) One idle cycle between pointer read and pointer use.
// (RULE15) On a 16-bit bus 32-bit data splits into two cycles.
// (RULE16) 16-byte units refused when an on-chip module is involved.
// (RULE17) Single mode: one cycle, strobe one device, address the other.
// (RULE18) Single mode only between external parties, never on-chip.
// (RULE19) Single mode requests come only from the external request pin.
// (RULE20) Each channel takes burst or cycle steal from its control bits.
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "dmaca_regs.vh"
module dmaca_core (
  input wire ref_clk,
  input wire rst,
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [3:0] chReq,
  input wire nmiIn,
  output wire [31:0] memAddr,
  output wire memRd,
  output wire memWr,
  output wire [1:0] memSize,
  output wire [31:0] memWdata,
  input wire [31:0] memRdata,
  input wire memDone,
  output wire [3:0] transferAckStrobe,
  output wire busHold
);
  localparam ST_IDLE = 7'h01;
  localparam ST_PTR = 7'h02;
  localparam ST_NOP = 7'h04;
  localparam ST_RD = 7'h08;
  localparam ST_WR = 7'h10;
  localparam ST_SGL = 7'h20;
  localparam ST_DONE = 7'h40;

  reg [6:0] state_r;
  reg [1:0] chan_r;
  reg [2:0] beat_r;
  reg [31:0] ptr_r;
  reg [31:0] dbuf_r [0:3];
  reg [31:0] sar_r [0:3];
  reg [31:0] dar_r [0:3];
  reg [23:0] cnt_r [0:3];
  reg [10:0] ctl_r [0:3];
  reg [3:0] te_r;
  reg men_r;
  reg nmi_abort_flag_r;
  reg narrow_r;
  reg [1:0] pri_r;
  reg [7:0] order_r;
  reg waitReq_r;
  reg [31:0] rdData_r;
  reg [31:0] memAddr_r;
  reg [31:0] memWdata_r;
  reg memRd_r;
  reg memWr_r;
  reg [1:0] memSize_r;
  reg [3:0] ack_r;
  reg busHold_r;
  reg [7:0] actOrder;
  reg [31:0] rdVal;
  integer i;

  assign avs_readdata = rdData_r;
  assign avs_waitrequest = waitReq_r;
  assign memAddr = memAddr_r;
  assign memRd = memRd_r;
  assign memWr = memWr_r;
  assign memSize = memSize_r;
  assign memWdata = memWdata_r;
  assign transferAckStrobe = ack_r;
  assign busHold = busHold_r;

  function [2:0] pickChan;
    input [7:0] ord;
    input [3:0] elig;
    integer k;
    reg [1:0] c;
    begin
      pickChan = 3'h0;
      for (k = 3; k >= 0; k = k - 1) begin
        c = ord[2*k +: 2];
        if (elig[c]) begin
          pickChan = {1'b1, c};
        end
      end
    end
  endfunction

  function [7:0] rrRotate;
    input [7:0] ord;
    input [1:0] c;
    integer k;
    integer n;
    reg [7:0] o;
    begin
      o = 8'h00;
      n = 0;
      for (k = 0; k < 4; k = k + 1) begin
        if (ord[2*k +: 2] != c) begin
          o[2*n +: 2] = ord[2*k +: 2];
          n = n + 1;
        end
      end
      o[7:6] = c;
      rrRotate = o;
    end
  endfunction

  function [31:0] beMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      beMerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          beMerge[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  // Request qualification, one gate per channel
  wire [3:0] grantable;
  wire [3:0] refused;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gGate
      dmaca_req_gate #(
        .INDIRECT_OK(g == 3)
      ) uGate (
        .reqIn(chReq[g]),
        .chEnable(ctl_r[g][`DMACA_CCR_CE]),
        .masterEnable(men_r),
        .endFlag(te_r[g]),
        .abortFlag(nmi_abort_flag_r),
        .singleMode(ctl_r[g][`DMACA_CCR_SINGLE]),
        .indirectMode(ctl_r[g][`DMACA_CCR_IND]),
        .quadSize(ctl_r[g][`DMACA_CCR_SZ_HI:`DMACA_CCR_SZ_LO] ==
          `DMACA_SZ_QUAD),
        .onChip(ctl_r[g][`DMACA_CCR_ONCHIP]),
        .cfgRefused(refused[g]),
        .grantable(grantable[g])
      );
    end
  endgenerate

  always @* begin
    case (pri_r) // (RULE3)
      `DMACA_PRI_FIX_A: actOrder = `DMACA_ORDER_FIX_A; // (RULE4) (RULE5)
      `DMACA_PRI_FIX_B: actOrder = `DMACA_ORDER_FIX_B; // (RULE4) (RULE5)
      `DMACA_PRI_FIX_C: actOrder = `DMACA_ORDER_FIX_C; // (RULE4) (RULE5)
      default: actOrder = order_r;
    endcase
  end

  wire [2:0] pick = pickChan(actOrder, grantable); // (RULE2) (RULE8)
  wire [10:0] pickCtl = ctl_r[pick[1:0]];
  wire [10:0] curCtl = ctl_r[chan_r];
  wire [1:0] curSz = curCtl[`DMACA_CCR_SZ_HI:`DMACA_CCR_SZ_LO];
  wire curQuad = curSz == `DMACA_SZ_QUAD;
  wire splitHalf = narrow_r & curSz[1]; // (RULE15)
  wire [2:0] beatBytes = splitHalf ? 3'h2 :
    (curSz == `DMACA_SZ_BYTE) ? 3'h1 :
    (curSz == `DMACA_SZ_WORD) ? 3'h2 : 3'h4;
  wire [2:0] lastBeat = curQuad ? (splitHalf ? 3'h7 : 3'h3) :
    (splitHalf ? 3'h1 : 3'h0);
  wire [2:0] ptrLast = narrow_r ? 3'h1 : 3'h0;
  wire [5:0] beatOff = {3'b000, beat_r} * {3'b000, beatBytes};
  wire [4:0] unitBytes = curQuad ? 5'h10 : {2'b00, beatBytes << splitHalf};
  wire [1:0] wIdx = splitHalf ? beat_r[2:1] : beat_r[1:0];
  wire [1:0] beatSize = curQuad ? `DMACA_SZ_LONG :
    (splitHalf ? `DMACA_SZ_WORD : curSz);
  wire [31:0] curSar = sar_r[chan_r];
  wire [31:0] curDar = dar_r[chan_r];
  wire [31:0] rdBase = curCtl[`DMACA_CCR_IND] ? ptr_r : curSar; // (RULE11)
  wire [31:0] wBuf = dbuf_r[wIdx];
  wire chanOk = men_r & ~nmi_abort_flag_r & curCtl[`DMACA_CCR_CE];
  wire cycOut = memRd_r | memWr_r;
  wire working = (state_r != ST_IDLE) & (state_r != ST_DONE);

  // Avalon access completes on the edge where waitrequest is low
  wire busWr = avs_write & ~waitReq_r;
  wire gorHit = {avs_address[6:2], 2'b00} == `DMACA_OFF_GOR;
  wire chHit = {avs_address[6], 6'h00} == `DMACA_OFF_CHAN;
  wire [1:0] regCh = avs_address[5:4];
  wire [1:0] regSub = avs_address[3:2];
  wire gorWr = busWr & gorHit;
  wire chWr = busWr & chHit;
  wire [31:0] wrCcr = beMerge({21'h00_0000, ctl_r[regCh]}, avs_writedata,
    avs_byteenable);
  wire [31:0] wrSar = beMerge(sar_r[regCh], avs_writedata, avs_byteenable);
  wire [31:0] wrDar = beMerge(dar_r[regCh], avs_writedata, avs_byteenable);
  wire [31:0] wrCnt = beMerge({8'h00, cnt_r[regCh]}, avs_writedata,
    avs_byteenable);
  wire ccrWr = chWr & (regSub == `DMACA_SUB_CCR);
  wire teClrReq = ccrWr & avs_byteenable[0] &
    ~avs_writedata[`DMACA_CCR_TE];
  wire endUnit = (state_r == ST_DONE) & (cnt_r[chan_r] == 24'h00_0001);
  wire nmifClr = gorWr & avs_byteenable[0] & ~avs_writedata[`DMACA_GOR_NMI_ABORT_FLAG];

  always @* begin
    rdVal = 32'h0000_0000;
    if (gorHit) begin
      rdVal[`DMACA_GOR_MEN] = men_r;
      rdVal[`DMACA_GOR_NMI_ABORT_FLAG] = nmi_abort_flag_r;
      rdVal[`DMACA_GOR_NARROW] = narrow_r;
      rdVal[`DMACA_GOR_PRI_HI:`DMACA_GOR_PRI_LO] = pri_r;
      rdVal[`DMACA_GOR_BUSY] = state_r != ST_IDLE;
      rdVal[`DMACA_GOR_CHAN_HI:`DMACA_GOR_CHAN_LO] = chan_r;
    end else if (chHit) begin
      case (regSub)
        `DMACA_SUB_CCR: begin
          rdVal[10:0] = ctl_r[regCh];
          rdVal[`DMACA_CCR_TE] = te_r[regCh];
          rdVal[`DMACA_CCR_REFUSED] = refused[regCh];
        end
        `DMACA_SUB_SAR: rdVal = sar_r[regCh];
        `DMACA_SUB_DAR: rdVal = dar_r[regCh];
        default: rdVal = {8'h00, cnt_r[regCh]};
      endcase
    end
  end

  // Bus slave handshake and flags that hardware sets
  always @(posedge ref_clk) begin
    if (rst) begin
      waitReq_r <= 1'b1;
      rdData_r <= 32'h0000_0000;
      te_r <= 4'h0;
      nmi_abort_flag_r <= 1'b0;
    end else begin
      waitReq_r <= ~((avs_read | avs_write) & waitReq_r);
      if (avs_read & waitReq_r) begin
        rdData_r <= rdVal;
      end
      // A set in the same cycle as a clear wins
      for (i = 0; i < 4; i = i + 1) begin
        te_r[i] <= (endUnit & (chan_r == i)) |
          (te_r[i] & ~(teClrReq & (regCh == i)));
      end
      nmi_abort_flag_r <= nmiIn | (nmi_abort_flag_r & ~nmifClr);
    end
  end

  // Transfer sequencer and software-written registers
  always @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      chan_r <= 2'h0;
      beat_r <= 3'h0;
      ptr_r <= 32'h0000_0000;
      men_r <= 1'b0;
      narrow_r <= 1'b0;
      pri_r <= `DMACA_PRI_FIX_A;
      order_r <= `DMACA_ORDER_RR_RESET; // (RULE7)
      memAddr_r <= 32'h0000_0000;
      memWdata_r <= 32'h0000_0000;
      memRd_r <= 1'b0;
      memWr_r <= 1'b0;
      memSize_r <= `DMACA_SZ_BYTE;
      ack_r <= 4'h0;
      busHold_r <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        dbuf_r[i] <= 32'h0000_0000;
        sar_r[i] <= `DMACA_ADDR_RESET;
        dar_r[i] <= `DMACA_ADDR_RESET;
        cnt_r[i] <= `DMACA_CNT_RESET;
        ctl_r[i] <= `DMACA_CCR_RESET;
      end
    end else begin
      if (working & ~chanOk & ~cycOut) begin
        // Abort only between bus cycles so no cycle is cut short
        state_r <= ST_IDLE;
        busHold_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            beat_r <= 3'h0;
            busHold_r <= pick[2] & pickCtl[`DMACA_CCR_BURST]; // (RULE20)
            if (pick[2]) begin
              chan_r <= pick[1:0]; // (RULE2) (RULE8)
              if (pickCtl[`DMACA_CCR_SINGLE]) begin
                state_r <= ST_SGL;
              end else if (pickCtl[`DMACA_CCR_IND]) begin
                state_r <= ST_PTR;
              end else begin
                state_r <= ST_RD;
              end
            end
          end
          ST_PTR: begin
            if (~cycOut) begin
              memRd_r <= 1'b1;
              memAddr_r <= curSar + {{28{1'b0}}, beat_r, 1'b0};
              memSize_r <= narrow_r ? `DMACA_SZ_WORD : `DMACA_SZ_LONG; // (RULE12)
            end else if (memDone) begin
              memRd_r <= 1'b0;
              if (~narrow_r) begin
                ptr_r <= memRdata; // (RULE12)
              end else if (beat_r[0]) begin
                ptr_r[15:0] <= memRdata[15:0];
              end else begin
                ptr_r[31:16] <= memRdata[15:0];
              end
              beat_r <= (beat_r == ptrLast) ? 3'h0 : beat_r + 3'h1;
              if (beat_r == ptrLast) begin
                state_r <= ST_NOP;
              end
            end
          end
          ST_NOP: state_r <= ST_RD; // (RULE14)
          ST_RD: begin
            if (~cycOut) begin
              memRd_r <= 1'b1; // (RULE9) (RULE10)
              memAddr_r <= rdBase + {{26{1'b0}}, beatOff};
              memSize_r <= beatSize; // (RULE15)
            end else if (memDone) begin
              memRd_r <= 1'b0;
              if (~splitHalf) begin
                dbuf_r[wIdx] <= memRdata; // (RULE10)
              end else if (beat_r[0]) begin
                dbuf_r[wIdx][15:0] <= memRdata[15:0];
              end else begin
                dbuf_r[wIdx][31:16] <= memRdata[15:0];
              end
              beat_r <= (beat_r == lastBeat) ? 3'h0 : beat_r + 3'h1;
              if (beat_r == lastBeat) begin
                state_r <= ST_WR;
              end
            end
          end
          ST_WR: begin
            if (~cycOut) begin
              memWr_r <= 1'b1; // (RULE9) (RULE10)
              memAddr_r <= curDar + {{26{1'b0}}, beatOff};
              memSize_r <= beatSize; // (RULE15)
              if (~splitHalf) begin
                memWdata_r <= wBuf;
              end else if (beat_r[0]) begin
                memWdata_r <= {16'h0000, wBuf[15:0]};
              end else begin
                memWdata_r <= {16'h0000, wBuf[31:16]};
              end
            end else if (memDone) begin
              memWr_r <= 1'b0;
              beat_r <= (beat_r == lastBeat) ? 3'h0 : beat_r + 3'h1;
              if (beat_r == lastBeat) begin
                state_r <= ST_DONE;
              end
            end
          end
          ST_SGL: begin
            // The strobed device drives or takes the data bus itself
            if (~cycOut) begin
              ack_r[chan_r] <= 1'b1; // (RULE17) (RULE19)
              memSize_r <= curQuad ? `DMACA_SZ_LONG : curSz;
              if (curCtl[`DMACA_CCR_DEV2MEM]) begin
                memWr_r <= 1'b1;
                memAddr_r <= curDar;
              end else begin
                memRd_r <= 1'b1;
                memAddr_r <= curSar;
              end
            end else if (memDone) begin
              memRd_r <= 1'b0; // (RULE17)
              memWr_r <= 1'b0;
              ack_r <= 4'h0;
              state_r <= ST_DONE;
            end
          end
          ST_DONE: begin
            if (curCtl[`DMACA_CCR_SRCINC] & ~curCtl[`DMACA_CCR_IND]) begin
              sar_r[chan_r] <= curSar + {{27{1'b0}}, unitBytes};
            end
            if (curCtl[`DMACA_CCR_DSTINC]) begin
              dar_r[chan_r] <= curDar + {{27{1'b0}}, unitBytes};
            end
            cnt_r[chan_r] <= cnt_r[chan_r] - 24'h00_0001;
            if (pri_r == `DMACA_PRI_RR) begin
              order_r <= rrRotate(order_r, chan_r); // (RULE6)
            end
            // Cycle steal gives the bus back between units
            busHold_r <= busHold_r & curCtl[`DMACA_CCR_BURST]; // (RULE20)
            state_r <= ST_IDLE;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
      // Software writes land after the sequencer, so they take precedence
      if (gorWr & avs_byteenable[0]) begin
        men_r <= avs_writedata[`DMACA_GOR_MEN];
        narrow_r <= avs_writedata[`DMACA_GOR_NARROW];
      end
      if (gorWr & avs_byteenable[1]) begin
        pri_r <= avs_writedata[`DMACA_GOR_PRI_HI:`DMACA_GOR_PRI_LO];
      end
      if (chWr) begin
        case (regSub)
          `DMACA_SUB_CCR: ctl_r[regCh] <= wrCcr[10:0] & ~`DMACA_CCR_TE_MASK;
          `DMACA_SUB_SAR: sar_r[regCh] <= wrSar;
          `DMACA_SUB_DAR: dar_r[regCh] <= wrDar;
          default: cnt_r[regCh] <= wrCnt[23:0];
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/dmaca_req_gate.v ====
`timescale 1ns/1ns
`default_nettype none
module dmaca_req_gate #(
  parameter [0:0] INDIRECT_OK = 1'b0
) (
  input wire reqIn,
  input wire chEnable,
  input wire masterEnable,
  input wire endFlag,
  input wire abortFlag,
  input wire singleMode,
  input wire indirectMode,
  input wire quadSize,
  input wire onChip,
  output wire cfgRefused,
  output wire grantable
);
  // Illegal combinations never start; software sees them as refused
  wire badSingle = singleMode & onChip; // (RULE18)
  wire badQuad = quadSize & (onChip | (indirectMode & ~singleMode)); // (RULE13) (RULE16)
  wire badInd = indirectMode & ~singleMode & ~INDIRECT_OK; // (RULE11)

  assign cfgRefused = badSingle | badQuad | badInd;
  assign grantable = reqIn & chEnable & masterEnable & ~endFlag & ~abortFlag &
    ~cfgRefused; // (RULE1)
endmodule
`default_nettype wire

// ==== tb/dma_channel_arbiter_and_address_modes_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module dma_channel_arbiter_and_address_modes_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] avs_address = 7'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  wire logic [31:0] avs_readdata, memAddr, memWdata, memRdata;
  wire logic avs_waitrequest, memRd, memWr, memDone, busHold;
  wire logic [1:0] memSize;
  wire logic [3:0] transferAckStrobe;
  logic [3:0] chReq = 4'h0;
  logic nmiIn = 1'b0;
  logic [3:0] waitCycles = 4'h0;
  logic holdSeen = 1'b0;
  logic [31:0] d;
  int failures = 0;
  int cmp_count = 0;
  int gapRef = 0;
  logic [31:0] ordTab[4] = '{32'h0011_2233, 32'h0022_3311, 32'h2200_1133,
    32'h0123_0123};
  int chT[4] = '{3, 0, 0, 1};
  logic [31:0] ccrT[4] = '{32'h0000_002D, 32'h0000_010D, 32'h0000_0141,
    32'h0000_0021};

  dmaca_core i_dmaca_core (.ref_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .chReq, .nmiIn, .memAddr, .memRd, .memWr, .memSize,
    .memWdata, .memRdata, .memDone, .transferAckStrobe, .busHold);
  dmaca_mem_model i_dmaca_mem_model (.ref_clk, .rst, .memRd, .memWr,
    .memAddr, .memSize, .memWdata, .transferAckStrobe, .waitCycles,
    .memDone, .memRdata);

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (busHold === 1'b1) holdSeen <= 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic cfg(input int c, input logic [31:0] ccr, sa, da, n);
    logic [6:0] b;
    b = 7'h40 + 7'(c * 16);
    wr(b + 7'h4, sa);
    wr(b + 7'h8, da);
    wr(b + 7'hC, n);
    wr(b, ccr);
  endtask
  function automatic logic [31:0] ta(input int i);
    return i_dmaca_mem_model.trace[i].a;
  endfunction
  function automatic logic [31:0] nBeats();
    return 32'(i_dmaca_mem_model.trace.size());
  endfunction
  task automatic waitBeats(input int n);
    int k;
    k = 0;
    while (nBeats() < 32'(n) && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    // Extra cycles expose any beat beyond the expected count
    repeat (12) @(posedge ref_clk);
    chk(nBeats(), 32'(n));
  endtask
  task automatic waitRd;
    int k;
    k = 0;
    while (memRd !== 1'b1 && k < 500) begin
      @(posedge ref_clk);
      k++;
    end
  endtask
  task automatic clearRun;
    chReq <= 4'h0;
    i_dmaca_mem_model.trace.delete();
  endtask

  task automatic tReg;
    rd(7'h00, d);
    chk(d, 32'h0);
    rd(7'h40, d);
    chk(d, 32'h0);
    wr(7'h20, 32'hFFFF_FFFF);
    rd(7'h20, d);
    chk(d, 32'h0);
  endtask
  task automatic tDirect;
    cfg(0, 32'h0000_0009, 32'h0000_0100, 32'h0000_0200, 32'h1);
    chReq <= 4'h1;
    repeat (10) @(posedge ref_clk);
    chk(nBeats(), 32'h0);
    wr(7'h00, 32'h0000_0001);
    waitBeats(2);
    chk(ta(0), 32'h0000_0100);
    chk(ta(1), 32'h0000_0200);
    chk(i_dmaca_mem_model.trace[1].wr, 32'h1);
    chk(i_dmaca_mem_model.trace[1].d, 32'h5A5A_0100);
    rd(7'h40, d);
    chk(d, 32'h0000_000B);
    chk(holdSeen, 32'h0);
    gapRef = i_dmaca_mem_model.trace[1].t0 - i_dmaca_mem_model.trace[0].t1;
    clearRun();
  endtask
  task automatic tPrio(input int m);
    for (int c = 0; c < 4; c++) begin
      cfg(c, 32'h1, 32'(c + 1) << 12, 32'h0000_0800, 32'h2);
    end
    wr(7'h00, (32'(m) << 8) | 32'h1);
    chReq <= 4'hF;
    waitBeats(16);
    for (int u = 0; u < 8; u++) begin
      chk(ta(2 * u), {16'h0, ordTab[m][31 - 4 * u -: 4] + 4'h1, 12'h0});
    end
    clearRun();
  endtask
  task automatic tLate;
    waitCycles <= 4'h3;
    cfg(0, 32'h1, 32'h0000_1000, 32'h0000_0800, 32'h1);
    cfg(1, 32'h1, 32'h0000_2000, 32'h0000_0800, 32'h1);
    cfg(3, 32'h1, 32'h0000_4000, 32'h0000_0800, 32'h1);
    chReq <= 4'h9;
    waitRd();
    chReq <= 4'hB;
    waitBeats(6);
    chk(ta(0), 32'h0000_1000);
    chk(ta(2), 32'h0000_2000);
    chk(ta(4), 32'h0000_4000);
    waitCycles <= 4'h0;
    clearRun();
  endtask
  task automatic tInd;
    wr(7'h00, 32'h0000_0001);
    cfg(3, 32'h0000_0025, 32'h0000_0300, 32'h0000_0400, 32'h1);
    chReq <= 4'h8;
    waitBeats(3);
    chk(ta(0), 32'h0000_0300);
    chk(i_dmaca_mem_model.trace[0].sz, 32'h2);
    chk(ta(1), 32'h5A5A_0300);
    chk(ta(2), 32'h0000_0400);
    chk(i_dmaca_mem_model.trace[2].d, 32'h0000_0300);
    chk(32'(i_dmaca_mem_model.trace[1].t0 - i_dmaca_mem_model.trace[0].t1),
      32'(gapRef + 1));
    clearRun();
    // Narrow bus: pointer and 32-bit data each split into two half beats
    wr(7'h00, 32'h0000_0005);
    cfg(3, 32'h0000_0029, 32'h0000_0300, 32'h0000_0400, 32'h1);
    chReq <= 4'h8;
    waitBeats(6);
    chk(ta(1), 32'h0000_0302);
    chk(ta(2), 32'h0300_0302);
    chk(ta(5), 32'h0000_0402);
    chk(i_dmaca_mem_model.trace[2].sz, 32'h1);
    chk(i_dmaca_mem_model.trace[4].d, 32'h0000_0302);
    clearRun();
  endtask
  task automatic tRefuse;
    for (int i = 0; i < 4; i++) begin
      cfg(chT[i], ccrT[i], 32'h0000_0100, 32'h0000_0200, 32'h1);
      rd(7'h40 + 7'(chT[i] * 16), d);
      chk(d, ccrT[i] | 32'h0000_0800);
      chReq <= 4'hF;
      repeat (20) @(posedge ref_clk);
      chk(nBeats(), 32'h0);
      chReq <= 4'h0;
    end
  endtask
  task automatic tSingle;
    for (int i = 0; i < 2; i++) begin
      cfg(0, i ? 32'h41 : 32'hC1, 32'h0000_0600, 32'h0000_0500, 32'h1);
      chReq <= 4'h1;
      waitBeats(1);
      chk(i_dmaca_mem_model.trace[0].wr, i ? 32'h0 : 32'h1);
      chk(ta(0), i ? 32'h0000_0600 : 32'h0000_0500);
      chk(i_dmaca_mem_model.trace[0].ack, 32'h1);
      clearRun();
    end
  endtask
  task automatic tAbort;
    cfg(0, 32'h0000_0011, 32'h0000_0100, 32'h0000_0200, 32'h3);
    chReq <= 4'h1;
    waitRd();
    nmiIn <= 1'b1;
    @(posedge ref_clk);
    nmiIn <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk(nBeats(), 32'h1);
    rd(7'h00, d);
    chk(d[1], 32'h1);
    chk(holdSeen, 32'h1);
    wr(7'h00, 32'h0000_0001);
    clearRun();
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #3_000_000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    tReg();
    tDirect();
    for (int m = 0; m < 4; m++) tPrio(m);
    tLate();
    tInd();
    tRefuse();
    tSingle();
    tAbort();
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== tb/dmaca_core_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module dmaca_core_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic nmiIn,
  input wire logic [31:0] memAddr,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [1:0] memSize,
  input wire logic [31:0] memWdata,
  input wire logic memDone,
  input wire logic [3:0] transferAckStrobe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence sBeatOpen;
    (memRd || memWr) && !memDone;
  endsequence
  sequence sBeatEnd;
    (memRd || memWr) && memDone;
  endsequence
  sequence sBusIdle;
    !memRd && !memWr;
  endsequence
  a_avs_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait not one cycle");
  a_beat_held: assert property (sBeatOpen |=>
    $stable({memRd, memWr, memAddr, memSize, memWdata, transferAckStrobe}))
    else $error("bus request changed before done");
  a_beat_release: assert property (sBeatEnd |=> sBusIdle)
    else $error("bus request not dropped after done");
  a_rd_wr_excl: assert property (!(memRd && memWr))
    else $error("read and write together");
  a_one_ack: assert property ($onehot0(transferAckStrobe))
    else $error("more than one channel acknowledged");
  a_ack_in_beat: assert property (transferAckStrobe != 4'h0 |->
    memRd || memWr) else $error("acknowledge outside a bus cycle");
  // The beat in flight may finish; no new beat may start once aborted
  a_abort_quiet: assert property (nmiIn |=> ##2
    (!$rose(memRd) && !$rose(memWr))[*4]) else $error("beat after abort");
  a_reset_quiet: assert property ($fell(rst) |-> sBusIdle and
    (avs_waitrequest && transferAckStrobe == 4'h0))
    else $error("outputs busy after reset");
endmodule
bind dmaca_core dmaca_core_properties i_dmaca_core_properties (.ref_clk,
  .rst, .avs_read, .avs_write, .avs_waitrequest, .nmiIn, .memAddr, .memRd,
  .memWr, .memSize, .memWdata, .memDone, .transferAckStrobe);
`default_nettype wire

// ==== tb/dmaca_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dmaca_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [31:0] memAddr,
  input wire logic [1:0] memSize,
  input wire logic [31:0] memWdata,
  input wire logic [3:0] transferAckStrobe,
  input wire logic [3:0] waitCycles,
  output logic memDone = 1'b0,
  output logic [31:0] memRdata = 32'h0
);
  typedef struct {logic wr; logic [31:0] a; logic [1:0] sz; logic [31:0] d;
    logic [3:0] ack; int t0; int t1;} dmaca_beat_t;
  dmaca_beat_t trace[$];
  int cyc = 0;
  int st = 0;
  logic [3:0] cnt = 4'h0;
  logic busy = 1'b0;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    memDone <= 1'b0;
    // Released data lines keep toggling so a stale sample never matches
    memRdata <= ~memRdata;
    if (rst) begin
      cnt <= 4'h0;
      busy <= 1'b0;
    end else if ((memRd || memWr) && !memDone) begin
      if (!busy) begin
        st <= cyc;
        busy <= 1'b1;
      end
      if (cnt == waitCycles) begin
        memDone <= 1'b1;
        cnt <= 4'h0;
        busy <= 1'b0;
        if (memRd) begin
          memRdata <= memAddr ^ 32'h5A5A_0000;
        end
        trace.push_back('{memWr, memAddr, memSize, memWr ? memWdata :
          memAddr ^ 32'h5A5A_0000, transferAckStrobe, busy ? st : cyc, cyc});
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
